// [hdl/taskfile_decode.v]
// Operation
// - common memory selected: registers sit in lowest 2 KByte, higher address bits ignored
// - both lane enables low: offset 0 is a 16-bit data word
// - low lane only: two byte accesses at 0 give even then odd byte
// - high lane only at 0: error on read, features on write
// - offsets 8, 9, D duplicate 0 and 1 without overlapping
// - offset 8 equals 0, 9 gives odd byte; 9 then 8 moves odd, even
// - repeated byte accesses at 8 or 0 step bytes even then odd
// - repeated word accesses at 8, 9 or 0 step consecutive words
// - alternating byte accesses 8 then 9 step bytes even then odd
// - even addresses in upper kilobyte decode as offset 8
// - odd addresses in upper kilobyte decode as offset 9
// - upper kilobyte reaches only the sequential fifo, no random access
// - word access at 8: even byte on low lane, odd byte high lane
`include "taskfile_consts.vh"

module taskfile_decode (
    // clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // host access, one-cycle strobes
    input wire reg_select,
    input wire [10:0] addr,
    input wire low_lane_enable_n,
    input wire high_lane_enable_n,
    input wire rd_strobe,
    input wire wr_strobe,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    output reg rd_valid,
    // card side: data toward host
    input wire [15:0] card_word,
    input wire card_word_valid,
    output wire card_word_ready,
    // card side: data from host
    output reg [15:0] host_word,
    output reg host_word_valid,
    input wire host_word_ready,
    // card side: status inputs
    input wire [7:0] fault_info,
    input wire [7:0] condition,
    input wire [7:0] unit_address,
    // card side: register contents
    output reg [7:0] option_select,
    output reg [7:0] transfer_block_count,
    output reg [7:0] start_block_low,
    output reg [7:0] track_address_low,
    output reg [7:0] track_address_high,
    output reg [7:0] unit_and_head_select,
    output reg [7:0] opcode,
    output reg opcode_strobe,
    output reg [7:0] device_control
);

////////////////////////////////////////////////////////////////////////////////
// address decode

// upper kilobyte folds onto 8/9 by a0 alone; lower kilobyte uses a3..a0 only
function [3:0] eff_offset;
    input [10:0] a;
    begin
        if (a[`ADDR_WINDOW_BIT])
            eff_offset = a[0] ? `OFS_DATA_ODD_DUP : `OFS_DATA_EVEN_DUP;
        else
            eff_offset = a[3:0];
    end
endfunction

wire [3:0] ofs;
wire access;
wire word_acc;
wire lo_only;
wire hi_only;
wire is_data_ofs;
wire data_word;
wire data_lo_byte;
wire data_hi_byte;
wire data_odd_byte;
wire fault_hit;

assign ofs = eff_offset(addr);
// i/o mode accesses belong to another decoder
assign access = reg_select && (rd_strobe || wr_strobe);
assign word_acc = !low_lane_enable_n && !high_lane_enable_n;
assign lo_only = !low_lane_enable_n && high_lane_enable_n;
assign hi_only = low_lane_enable_n && !high_lane_enable_n;
assign is_data_ofs = (ofs == `OFS_DATA) || (ofs == `OFS_DATA_EVEN_DUP) || (ofs == `OFS_DATA_ODD_DUP);
// word at offset 1 also treated as word data, as the overlap demands
assign data_word = word_acc && (is_data_ofs || ofs == `OFS_FAULT);
// low-lane byte at 0 or 8 steps even/odd
assign data_lo_byte = lo_only && ((ofs == `OFS_DATA) || (ofs == `OFS_DATA_EVEN_DUP));
// odd byte: low-lane at 9, or high-lane at 8/9
assign data_odd_byte = (lo_only && ofs == `OFS_DATA_ODD_DUP) ||
    (hi_only && (ofs == `OFS_DATA_EVEN_DUP || ofs == `OFS_DATA_ODD_DUP));
assign data_hi_byte = data_odd_byte;
assign fault_hit = (lo_only && (ofs == `OFS_FAULT || ofs == `OFS_FAULT_DUP)) ||
    (hi_only && (ofs == `OFS_DATA || ofs == `OFS_FAULT)) ||
    (word_acc && ofs == `OFS_FAULT_DUP);

////////////////////////////////////////////////////////////////////////////////
// read-side fifo and byte stepping

wire rf_valid;
wire [15:0] rf_data;
reg rf_pop;
// 0 = next byte is even half, 1 = odd half of the current word
reg byte_phase;
reg [7:0] wr_even;
reg next_byte_phase;
reg pop_now;

word_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
) u_read_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(card_word_valid),
    .in_ready(card_word_ready),
    .in_data(card_word),
    .out_valid(rf_valid),
    .out_ready(rf_pop),
    .out_data(rf_data)
);

always @*
begin
    pop_now = 1'b0;
    next_byte_phase = byte_phase;
    if (access && rd_strobe)
    begin
        if (data_word)
        begin
            pop_now = 1'b1;
            next_byte_phase = 1'b0;
        end
        else if (data_lo_byte)
        begin
            pop_now = byte_phase;
            next_byte_phase = !byte_phase;
        end
        else if (data_odd_byte)
        begin
            // odd byte closes the word whatever came before
            pop_now = 1'b1;
            next_byte_phase = 1'b0;
        end
    end
    else if (access && wr_strobe)
    begin
        if (data_lo_byte)
            next_byte_phase = !byte_phase;
        else if (data_word || data_odd_byte)
            next_byte_phase = 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registers and answers

always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        rd_data <= 16'h0000;
        rd_valid <= 1'b0;
        rf_pop <= 1'b0;
        byte_phase <= 1'b0;
        wr_even <= `RST_BYTE;
        host_word <= 16'h0000;
        host_word_valid <= 1'b0;
        option_select <= `RST_BYTE;
        transfer_block_count <= `RST_BYTE;
        start_block_low <= `RST_BYTE;
        track_address_low <= `RST_BYTE;
        track_address_high <= `RST_BYTE;
        unit_and_head_select <= `RST_BYTE;
        opcode <= `RST_BYTE;
        opcode_strobe <= 1'b0;
        device_control <= `RST_BYTE;
    end
    else
    begin
        rd_valid <= 1'b0;
        opcode_strobe <= 1'b0;
        rf_pop <= pop_now && rf_valid;
        byte_phase <= next_byte_phase;
        if (host_word_valid && host_word_ready)
            host_word_valid <= 1'b0;
        if (access && rd_strobe)
        begin
            rd_valid <= 1'b1;
            rd_data <= 16'h0000;
            // pop lags one cycle; stepping counts on strobes at least two cycles apart
            if (data_word)
                rd_data <= rf_data;
            else if (data_lo_byte)
                rd_data <= {8'h00, byte_phase ? rf_data[15:8] : rf_data[7:0]};
            else if (data_odd_byte && lo_only)
                rd_data <= {8'h00, rf_data[15:8]};
            else if (data_odd_byte)
                rd_data <= {rf_data[15:8], 8'h00};
            else if (fault_hit && hi_only)
                rd_data <= {fault_info, 8'h00};
            else if (fault_hit && word_acc)
                rd_data <= {fault_info, 8'h00};
            else if (fault_hit)
                rd_data <= {8'h00, fault_info};
            else if (!word_acc)
            begin
                case (ofs)
                    `OFS_COUNT: rd_data <= {8'h00, transfer_block_count};
                    `OFS_START: rd_data <= {8'h00, start_block_low};
                    `OFS_TRACK_LO: rd_data <= {8'h00, track_address_low};
                    `OFS_TRACK_HI: rd_data <= {8'h00, track_address_high};
                    `OFS_UNIT_HEAD: rd_data <= {8'h00, unit_and_head_select};
                    `OFS_COND: rd_data <= {8'h00, condition};
                    `OFS_SHADOW: rd_data <= {8'h00, condition};
                    `OFS_UNIT_ADDR: rd_data <= {8'h00, unit_address};
                    default: rd_data <= 16'h0000;
                endcase
            end
        end
        else if (access && wr_strobe)
        begin
            // a full outbound word overwrites the last one even if the card has not taken it
            if (data_word)
            begin
                host_word <= wr_data;
                host_word_valid <= 1'b1;
            end
            else if (data_lo_byte && !byte_phase)
                wr_even <= wr_data[7:0];
            else if (data_lo_byte || (data_odd_byte && lo_only))
            begin
                host_word <= {wr_data[7:0], wr_even};
                host_word_valid <= 1'b1;
            end
            else if (data_odd_byte)
            begin
                host_word <= {wr_data[15:8], wr_even};
                host_word_valid <= 1'b1;
            end
            else if (fault_hit && !lo_only)
                option_select <= wr_data[15:8];
            else if (fault_hit)
                option_select <= wr_data[7:0];
            else if (!word_acc)
            begin
                case (ofs)
                    `OFS_COUNT: transfer_block_count <= wr_data[7:0];
                    `OFS_START: start_block_low <= wr_data[7:0];
                    `OFS_TRACK_LO: track_address_low <= wr_data[7:0];
                    `OFS_TRACK_HI: track_address_high <= wr_data[7:0];
                    `OFS_UNIT_HEAD: unit_and_head_select <= wr_data[7:0];
                    `OFS_COND:
                    begin
                        opcode <= wr_data[7:0];
                        opcode_strobe <= 1'b1;
                    end
                    `OFS_SHADOW: device_control <= wr_data[7:0];
                    default: opcode_strobe <= 1'b0;
                endcase
            end
        end
    end
end

endmodule // taskfile_decode

// [hdl/taskfile_consts.vh]
`ifndef TASKFILE_CONSTS_VH
`define TASKFILE_CONSTS_VH

// register offsets within the lower kilobyte
`define OFS_DATA 4'h0
`define OFS_FAULT 4'h1
`define OFS_COUNT 4'h2
`define OFS_START 4'h3
`define OFS_TRACK_LO 4'h4
`define OFS_TRACK_HI 4'h5
`define OFS_UNIT_HEAD 4'h6
`define OFS_COND 4'h7
`define OFS_DATA_EVEN_DUP 4'h8
`define OFS_DATA_ODD_DUP 4'h9
`define OFS_FAULT_DUP 4'hd
`define OFS_SHADOW 4'he
`define OFS_UNIT_ADDR 4'hf

// address fields
`define ADDR_WINDOW_BIT 10
`define ADDR_TOP_BIT 10

// reset values of writable registers
`define RST_BYTE 8'h00

// fifo geometry
`define FIFO_WIDTH 16
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// [hdl/word_fifo.v]
module word_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
)(
    // clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

// full level sized to the counter, not cut from an untyped parameter
localparam [AW:0] FULL_COUNT = DEPTH;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
wire do_wr;
wire do_rd;

assign in_ready = (count != FULL_COUNT);
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr];
assign do_wr = in_valid && in_ready;
assign do_rd = out_valid && out_ready;

always @(posedge ref_clk)
begin
    if (do_wr)
    begin
        mem[wr_ptr] <= in_data;
    end
end

always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
    end
    else
    begin
        if (do_wr)
        begin
            wr_ptr <= wr_ptr + 1'b1;
        end
        if (do_rd)
        begin
            rd_ptr <= rd_ptr + 1'b1;
        end
        if (do_wr && !do_rd)
        begin
            count <= count + 1'b1;
        end
        else if (do_rd && !do_wr)
        begin
            count <= count - 1'b1;
        end
    end
end

endmodule // word_fifo

// [test/taskfile_decode_sva.sv]
module taskfile_decode_sva (
    // clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // host access
    input wire reg_select,
    input wire [10:0] addr,
    input wire low_lane_enable_n,
    input wire high_lane_enable_n,
    input wire rd_strobe,
    input wire wr_strobe,
    input wire [15:0] wr_data,
    input wire [15:0] rd_data,
    input wire rd_valid,
    // card side
    input wire [7:0] fault_info,
    input wire [7:0] condition,
    input wire [7:0] option_select,
    input wire [7:0] opcode,
    input wire opcode_strobe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // taken lower-kilobyte accesses by lane pattern
    wire lo = reg_select && !addr[10] && !low_lane_enable_n && high_lane_enable_n;
    wire hi0 = reg_select && !addr[10] && addr[3:0] == 4'h0 && low_lane_enable_n && !high_lane_enable_n;
    a_read_answer: assert property (reg_select && rd_strobe |=> rd_valid ##1 !rd_valid)
        else $error("read answer missing");
    a_io_ignored: assert property (!(reg_select && rd_strobe) |=> !rd_valid)
        else $error("answer without memory read");
    a_opcode_write: assert property (wr_strobe && lo && addr[3:0] == 4'h7 |=> opcode_strobe && opcode == $past(wr_data[7:0]))
        else $error("opcode write lost");
    a_opcode_cause: assert property (opcode_strobe |-> $past(wr_strobe && reg_select && !addr[10] && addr[3:0] == 4'h7))
        else $error("opcode pulse without write");
    a_features_high: assert property (wr_strobe && hi0 |=> option_select == $past(wr_data[15:8]))
        else $error("high lane write missed features");
    a_error_high: assert property (rd_strobe && hi0 |=> rd_data == {$past(fault_info), 8'h00})
        else $error("high lane read missed error");
    a_fault_dup: assert property (rd_strobe && lo && addr[3:0] == 4'hd |=> rd_data == {8'h00, $past(fault_info)})
        else $error("duplicate error read wrong");
    a_alt_status: assert property (rd_strobe && lo && addr[3:0] == 4'he |=> rd_data == {8'h00, $past(condition)})
        else $error("alternate status read wrong");
    a_window_sink: assert property (reg_select && wr_strobe && addr[10] |=> !opcode_strobe && $stable(option_select))
        else $error("window write reached a register");
endmodule // taskfile_decode_sva
////////////////////////////////////////////////////////////
bind taskfile_decode taskfile_decode_sva checker_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_select(reg_select),
    .addr(addr), .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .fault_info(fault_info), .condition(condition), .option_select(option_select), .opcode(opcode),
    .opcode_strobe(opcode_strobe));

// [test/card_buffer_model.sv]
module card_buffer_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bench control
    input wire logic feed,
    input wire logic stall,
    // toward the decoder
    output logic [15:0] card_word,
    output logic card_word_valid,
    input wire logic card_word_ready,
    output logic host_word_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] even_byte;
    logic [15:0] last_word;
    // word k holds bytes 10h+2k (even) and 11h+2k (odd)
    assign card_word_valid = feed;
    // idle bus shows the inverse of the last word, so a stale read cannot pass
    assign card_word = feed ? {even_byte + 8'h01, even_byte} : ~last_word;
    assign host_word_ready = !stall;
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            even_byte <= 8'h10;
            last_word <= 16'h0000;
        end
        else if (feed && card_word_ready)
        begin
            even_byte <= even_byte + 8'h02;
            last_word <= card_word;
        end
    end
endmodule // card_buffer_model

// [test/taskfile_decode_test.sv]
module taskfile_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [1:0] WORD = 2'b00, LO = 2'b10, HI = 2'b01;
    logic ref_clk = 0, sys_rst = 0, reg_select = 1, low_lane_enable_n = 1, high_lane_enable_n = 1;
    logic rd_strobe = 0, wr_strobe = 0, feed = 0, stall = 0;
    logic card_word_valid, card_word_ready, host_word_valid, host_word_ready, rd_valid;
    logic [10:0] addr = 11'h000;
    logic [15:0] wr_data = 16'h0000, rd_data, card_word, host_word, got;
    logic [7:0] fault_info = 8'h5a, condition = 8'h3c, unit_address = 8'hc3, option_select, opcode, device_control;
    int error_cnt = 0, total_checks = 0;
    always #5 ref_clk = ~ref_clk;
    taskfile_decode dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_select(reg_select), .addr(addr),
        .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n), .rd_strobe(rd_strobe),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .card_word(card_word),
        .card_word_valid(card_word_valid), .card_word_ready(card_word_ready), .host_word(host_word),
        .host_word_valid(host_word_valid), .host_word_ready(host_word_ready), .fault_info(fault_info),
        .condition(condition), .unit_address(unit_address), .option_select(option_select),
        .transfer_block_count(), .start_block_low(), .track_address_low(), .track_address_high(),
        .unit_and_head_select(), .opcode(opcode), .opcode_strobe(), .device_control(device_control));
    card_buffer_model partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .feed(feed), .stall(stall),
        .card_word(card_word), .card_word_valid(card_word_valid), .card_word_ready(card_word_ready),
        .host_word_ready(host_word_ready));
    ////////////////////////////////////////////////////////////
    function automatic [7:0] lb(input int k);
        lb = 8'h10 + 8'(2 * k);
    endfunction
    function automatic [7:0] hb(input int k);
        hb = 8'h11 + 8'(2 * k);
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one host access; strobe held for exactly the taking edge
    task automatic acc(input logic rd, input logic [10:0] a, input logic [1:0] en, input logic [15:0] wd);
        @(posedge ref_clk);
        rd_strobe <= rd;
        wr_strobe <= !rd;
        addr <= a;
        {high_lane_enable_n, low_lane_enable_n} <= en;
        wr_data <= wd;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        wr_strobe <= 1'b0;
        #1;
        got = rd_data;
        chk({15'h0000, rd_valid}, {15'h0000, rd & reg_select});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic check_registers;
        for (int i = 2; i <= 6; i++)
            acc(1'b0, {1'b0, 6'h2a, 4'(i)}, LO, {8'h00, 8'h20 + 8'(i)});
        @(posedge ref_clk);
        reg_select <= 1'b0;
        acc(1'b0, 11'h002, LO, 16'h00ff);
        @(posedge ref_clk);
        reg_select <= 1'b1;
        for (int i = 2; i <= 6; i++)
        begin
            acc(1'b1, {7'h00, 4'(i)}, LO, 16'h0000);
            chk(got, {8'h00, 8'h20 + 8'(i)});
        end
    endtask
    task automatic check_split;
        acc(1'b0, 11'h007, LO, 16'h00a7);
        chk({8'h00, opcode}, 16'h00a7);
        acc(1'b1, 11'h007, LO, 16'h0000);
        chk(got, {8'h00, condition});
        acc(1'b0, 11'h001, LO, 16'h0061);
        chk({8'h00, option_select}, 16'h0061);
        acc(1'b0, 11'h000, HI, 16'h9300);
        chk({8'h00, option_select}, 16'h0093);
        acc(1'b1, 11'h000, HI, 16'h0000);
        chk(got, {fault_info, 8'h00});
        acc(1'b1, 11'h00d, LO, 16'h0000);
        chk(got, {8'h00, fault_info});
        acc(1'b0, 11'h00e, LO, 16'h0044);
        chk({8'h00, device_control}, 16'h0044);
        acc(1'b1, 11'h00e, LO, 16'h0000);
        chk(got, {8'h00, condition});
        acc(1'b1, 11'h00f, LO, 16'h0000);
        chk(got, {8'h00, unit_address});
    endtask
    // fill the fifo until it refuses, then drain it through word, low-lane byte and high-lane byte reads
    task automatic check_stream;
        int n;
        n = 0;
        @(posedge ref_clk);
        feed <= 1'b1;
        while (card_word_ready !== 1'b0 && n < 50)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        feed <= 1'b0;
        chk({15'h0000, card_word_ready}, 16'h0000);
        acc(1'b1, 11'h000, WORD, 16'h0000);
        chk(got, {hb(0), lb(0)});
        acc(1'b1, 11'h009, WORD, 16'h0000);
        chk(got, {hb(1), lb(1)});
        acc(1'b1, 11'h008, WORD, 16'h0000);
        chk(got, {hb(2), lb(2)});
        acc(1'b1, 11'h000, LO, 16'h0000);
        chk(got, {8'h00, lb(3)});
        acc(1'b1, 11'h000, LO, 16'h0000);
        chk(got, {8'h00, hb(3)});
        // never two byte reads at 9 in a row
        acc(1'b1, 11'h009, LO, 16'h0000);
        chk(got, {8'h00, hb(4)});
        acc(1'b1, 11'h008, LO, 16'h0000);
        chk(got, {8'h00, lb(5)});
        acc(1'b1, 11'h009, LO, 16'h0000);
        chk(got, {8'h00, hb(5)});
        acc(1'b1, 11'h008, LO, 16'h0000);
        chk(got, {8'h00, lb(6)});
        acc(1'b1, 11'h008, LO, 16'h0000);
        chk(got, {8'h00, hb(6)});
        acc(1'b1, 11'h7fe, LO, 16'h0000);
        chk(got, {8'h00, lb(7)});
        acc(1'b1, 11'h401, LO, 16'h0000);
        chk(got, {8'h00, hb(7)});
        acc(1'b1, 11'h5a4, WORD, 16'h0000);
        chk(got, {hb(8), lb(8)});
        acc(1'b1, 11'h008, HI, 16'h0000);
        chk(got, {hb(9), 8'h00});
        for (int k = 10; k < 16; k++)
        begin
            acc(1'b1, 11'h000, WORD, 16'h0000);
            chk(got, {hb(k), lb(k)});
        end
        chk({15'h0000, card_word_ready}, 16'h0001);
    endtask
    // card stalls: the written word must stand until taken
    task automatic check_host_writes;
        @(posedge ref_clk);
        stall <= 1'b1;
        acc(1'b0, 11'h000, WORD, 16'hbeef);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({host_word_valid, host_word[14:0]}, 16'hbeef);
        chk(host_word, 16'hbeef);
        @(posedge ref_clk);
        stall <= 1'b0;
        acc(1'b0, 11'h7fe, LO, 16'h0034);
        acc(1'b0, 11'h401, LO, 16'h0012);
        chk(host_word, 16'h1234);
        chk({15'h0000, host_word_valid}, 16'h0001);
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        // a real rising edge so the asynchronous reset is seen at time zero
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        check_registers;
        check_split;
        check_stream;
        check_host_writes;
        report_and_stop;
    end
    // whole run is about 120 cycles
    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop;
    end
endmodule // taskfile_decode_test
